// file: rtl/monitor_config_readout_regs.sv
// Configuration and readout register bank of the thermal and fan monitor.
// Assumes a bus engine on the same clock giving one-cycle read and write
// strobes, converter results on the same clock, and a lock level from the
// lockable configuration register.
`timescale 1ns/1ps
module monitor_config_readout_regs
  import monitor_regs_pkg::*;
#(
  parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  input  wire logic                         cfg_lock,
  // converter results
  input  wire logic [NUM_TH-1:0][7:0]       thermal_live,
  input  wire logic [NUM_CH-1:0][CONV_W-1:0] conv_live,
  // fan drive
  input  wire logic [2:0][7:0]              max_duty,
  input  wire logic [2:0][7:0]              auto_duty,
  output logic      [2:0][7:0]              fan_duty,
  // bus timeout
  input  wire logic                         bus_in_txn,
  input  wire logic                         bus_activity,
  output logic                              bus_release,
  // core voltage sleep pin
  input  wire logic                         core_voltage_low_pin,
  output logic                              device_sleep,
  // configuration outputs
  output logic      [2:0]                   smoothing_slow,
  output logic                              smoothing_further_stretch,
  output logic                              overtemp_hysteresis_off,
  output logic                              force_full_fan_speed,
  output logic                              cpu_power_calc_flag,
  output logic                              spinup_style_select,
  output logic                              bus_timeout_off,
  output logic                              core_voltage_sleep_ctrl
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);

  logic [7:0]                    cfg6;
  logic [7:0]                    cfg7;
  logic [NUM_TH-1:0][7:0]        thermal;
  logic [NUM_CH-1:0][CONV_W-1:0] conv_val;
  logic [NUM_CH-1:0]             conv_frz;
  logic [NUM_CH-1:0]             frz_set;
  logic [NUM_CH-1:0]             frz_rel;
  logic [7:0]                    ext3;
  logic [7:0]                    ext1;
  logic [7:0]                    ext2;
  logic [7:0]                    next_rdata;
  logic [TW-1:0]                 tmo_cnt;
  logic                          sleep_meta;
  logic                          sleep_sync;
  logic                          wr6;
  logic                          wr7;

  assign wr6 = reg_wr && (reg_addr == ADDR_CFG6);
  assign wr7 = reg_wr && (reg_addr == ADDR_CFG7);

  // config six: fully lockable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg6 <= CFG6_RST;
    end else if (wr6 && !cfg_lock) begin
      cfg6 <= reg_wdata & CFG6_MASK;
    end
  end

  // config seven: force bit escapes the lock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg7 <= CFG7_RST;
    end else if (wr7 && !cfg_lock) begin
      cfg7 <= reg_wdata & CFG7_MASK;
    end else if (wr7) begin
      cfg7[C7_FORCE] <= reg_wdata[C7_FORCE];
    end
  end

  // field outputs, each taken straight from stored config bits
  assign smoothing_slow            = cfg6[C6_SLOW_LO +: 3];
  assign smoothing_further_stretch = cfg6[C6_STRETCH];
  assign core_voltage_sleep_ctrl   = cfg6[C6_SLEEP];
  assign overtemp_hysteresis_off   = cfg7[C7_HYS_OFF];
  assign force_full_fan_speed      = cfg7[C7_FORCE];
  assign cpu_power_calc_flag       = cfg7[C7_PWR_FLAG];
  assign spinup_style_select       = cfg7[C7_SPINUP];
  assign bus_timeout_off           = cfg7[C7_TMO_OFF];

  // fan duty override
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fan_duty <= '0;
    end else if (cfg7[C7_FORCE]) begin
      fan_duty <= max_duty;
    end else begin
      fan_duty <= auto_duty;
    end
  end

  // thermal readings follow the engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal <= {NUM_TH{OVERTEMP_SIGNAL_RST}};
    end else begin
      thermal <= thermal_live;
    end
  end

  // held conversion results
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign frz_set[g] = reg_rd && (reg_addr == EXT_ADDR[g]);
      assign frz_rel[g] = reg_rd && (reg_addr == UPPER_ADDR[g]);
      reading_freeze_hold #(
        .W   (CONV_W),
        .RST (CONV_RST)
      ) u_hold (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .live       (conv_live[g]),
        .freeze_set (frz_set[g]),
        .release_rd (frz_rel[g]),
        .value      (conv_val[g]),
        .frozen     (conv_frz[g])
      );
    end
  endgenerate

  // extended resolution images
  assign ext3 = {conv_val[0][1:0], conv_val[1][1:0], 4'h0};
  assign ext1 = {conv_val[5][1:0], conv_val[4][1:0],
                 conv_val[3][1:0], conv_val[2][1:0]};
  assign ext2 = {6'h00, conv_val[6][1:0]};

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      ADDR_CFG6: next_rdata = cfg6;
      ADDR_CFG7: next_rdata = cfg7;
      ADDR_EXT3: next_rdata = ext3;
      ADDR_EXT1: next_rdata = ext1;
      ADDR_EXT2: next_rdata = ext2;
      default:   next_rdata = 8'h00;
    endcase
    for (int i = 0; i < NUM_TH; i++) begin
      if (reg_addr == OVERTEMP_SIGNAL_ADDR[i]) begin
        next_rdata = thermal[i];
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (reg_addr == UPPER_ADDR[i]) begin
        next_rdata = conv_val[i][CONV_W-1:2];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // bus idle timer inside a transaction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt <= '0;
    end else if (!bus_in_txn || bus_activity) begin
      tmo_cnt <= '0;
    end else if (tmo_cnt != TMO_LAST + 1'b1) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_release <= 1'b0;
    end else begin
      bus_release <= bus_in_txn && !bus_activity
                     && !cfg7[C7_TMO_OFF]
                     && (tmo_cnt == TMO_LAST);
    end
  end

  // core voltage level, pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= core_voltage_low_pin;
      sleep_sync <= sleep_meta;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_sleep <= 1'b0;
    end else begin
      device_sleep <= cfg6[C6_SLEEP] && sleep_sync;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ext3_read;
    reg_rd && (reg_addr == ADDR_EXT3);
  endsequence

  sequence s_cur_upper_read;
    reg_rd && (reg_addr == UPPER_ADDR[0]);
  endsequence

  property p_lock_cfg6;
    (wr6 && cfg_lock) |=> $stable(cfg6);
  endproperty
  a_lock_cfg6 : assert property (p_lock_cfg6)
    else $error("config six changed while locked");

  property p_force_locked;
    (wr7 && cfg_lock)
      |=> (force_full_fan_speed == $past(reg_wdata[C7_FORCE]))
          && (cfg7[7:2] == $past(cfg7[7:2]));
  endproperty
  a_force_locked : assert property (p_force_locked)
    else $error("force bit not writable under lock");

  property p_force_duty;
    force_full_fan_speed |=> (fan_duty == $past(max_duty));
  endproperty
  a_force_duty : assert property (p_force_duty)
    else $error("fans not at maximum duty when forced");

  property p_hys_write;
    (wr7 && !cfg_lock)
      |=> overtemp_hysteresis_off == $past(reg_wdata[C7_HYS_OFF]);
  endproperty
  a_hys_write : assert property (p_hys_write)
    else $error("hysteresis bit not stored");

  property p_reserved_zero;
    (cfg6[5:3] == 3'h0) && (cfg7[7:5] == 3'h0);
  endproperty
  a_reserved_zero : assert property (p_reserved_zero)
    else $error("reserved config bits set");

  property p_thermal_read;
    (reg_rd && (reg_addr == OVERTEMP_SIGNAL_ADDR[0]))
      |=> reg_rdata == $past(thermal[0]);
  endproperty
  a_thermal_read : assert property (p_thermal_read)
    else $error("thermal zero readback wrong");

  property p_ext3_read;
    s_ext3_read |=> (reg_rdata[3:0] == 4'h0)
      && (reg_rdata[7:6] == $past(conv_val[0][1:0]));
  endproperty
  a_ext3_read : assert property (p_ext3_read)
    else $error("extended three layout wrong");

  property p_freeze_hold;
    s_ext3_read ##1 (!reg_rd [*2])
      |-> conv_frz[0] && $stable(conv_val[0]);
  endproperty
  a_freeze_hold : assert property (p_freeze_hold)
    else $error("frozen current reading moved");

  property p_freeze_release;
    (conv_frz[0] && !frz_set[0]) ##0 s_cur_upper_read |=> !conv_frz[0];
  endproperty
  a_freeze_release : assert property (p_freeze_release)
    else $error("upper read did not release freeze");

  property p_upper_read;
    (reg_rd && (reg_addr == UPPER_ADDR[6]))
      |=> reg_rdata == $past(conv_val[6][CONV_W-1:2]);
  endproperty
  a_upper_read : assert property (p_upper_read)
    else $error("supply upper byte readback wrong");

  property p_timeout;
    (bus_in_txn && !bus_activity && !bus_timeout_off
      && (tmo_cnt == TMO_LAST)) |=> bus_release;
  endproperty
  a_timeout : assert property (p_timeout)
    else $error("bus not released after idle time");

  property p_timeout_off;
    bus_timeout_off |=> !bus_release;
  endproperty
  a_timeout_off : assert property (p_timeout_off)
    else $error("bus released with timeout disabled");

  property p_sleep;
    (cfg6[C6_SLEEP] && sleep_sync) |=> device_sleep;
  endproperty
  a_sleep : assert property (p_sleep)
    else $error("sleep not taken from core voltage");

  property p_no_sleep;
    !cfg6[C6_SLEEP] |=> !device_sleep;
  endproperty
  a_no_sleep : assert property (p_no_sleep)
    else $error("sleep without enable");

  sequence s_cfg6_open_write;
    wr6 && !cfg_lock;
  endsequence

  sequence s_cfg7_open_write;
    wr7 && !cfg_lock;
  endsequence

  property p_slow_write;
    s_cfg6_open_write |=> smoothing_slow == $past(reg_wdata[C6_SLOW_LO +: 3]);
  endproperty
  a_slow_write : assert property (p_slow_write)
    else $error("smoothing slow bits not stored");

  property p_stretch_write;
    s_cfg6_open_write
      |=> smoothing_further_stretch == $past(reg_wdata[C6_STRETCH]);
  endproperty
  a_stretch_write : assert property (p_stretch_write)
    else $error("further stretch bit not stored");

  property p_pwr_flag_write;
    s_cfg7_open_write
      |=> cpu_power_calc_flag == $past(reg_wdata[C7_PWR_FLAG]);
  endproperty
  a_pwr_flag_write : assert property (p_pwr_flag_write)
    else $error("power calculation flag not stored");

  property p_spinup_write;
    s_cfg7_open_write
      |=> spinup_style_select == $past(reg_wdata[C7_SPINUP]);
  endproperty
  a_spinup_write : assert property (p_spinup_write)
    else $error("spin-up style bit not stored");

  property p_fan_auto;
    !force_full_fan_speed |=> (fan_duty == $past(auto_duty));
  endproperty
  a_fan_auto : assert property (p_fan_auto)
    else $error("fans not on loop duty when not forced");

endmodule

// file: rtl/monitor_regs_pkg.sv
// Package for the monitor configuration and readout register bank.
// Assumes one 10 MHz device clock and an 8-bit register port.
package monitor_regs_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CFG6  = 8'h10;
  localparam logic [7:0] ADDR_CFG7  = 8'h11;
  localparam logic [7:0] ADDR_EXT3  = 8'h1F;
  localparam logic [7:0] ADDR_EXT1  = 8'h76;
  localparam logic [7:0] ADDR_EXT2  = 8'h77;

  // channel order: current, termination, 2.5 V, core, own, 5 V, 12 V
  localparam int NUM_CH = 7;
  localparam int NUM_TH = 4;
  localparam int CONV_W = 10;
  localparam logic [NUM_CH-1:0][7:0] UPPER_ADDR =
    {8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h1E, 8'h1D};
  localparam logic [NUM_CH-1:0][7:0] EXT_ADDR =
    {8'h77, 8'h76, 8'h76, 8'h76, 8'h76, 8'h1F, 8'h1F};
  localparam logic [NUM_TH-1:0][7:0] OVERTEMP_SIGNAL_ADDR =
    {8'h1C, 8'h1B, 8'h1A, 8'h33};

  // reset values
  localparam logic [7:0] CFG6_RST   = 8'h00;
  localparam logic [7:0] CFG7_RST   = 8'h00;
  localparam logic [7:0] OVERTEMP_SIGNAL_RST  = 8'h80;
  localparam logic [9:0] CONV_RST   = 10'h000;

  // writable masks, reserved bits kept at zero
  localparam logic [7:0] CFG6_MASK  = 8'hC7;
  localparam logic [7:0] CFG7_MASK  = 8'h1F;

  // config six fields
  localparam int C6_SLOW_LO   = 0;
  localparam int C6_SLEEP     = 6;
  localparam int C6_STRETCH   = 7;
  // config seven fields
  localparam int C7_HYS_OFF   = 0;
  localparam int C7_FORCE     = 1;
  localparam int C7_PWR_FLAG  = 2;
  localparam int C7_SPINUP    = 3;
  localparam int C7_TMO_OFF   = 4;

  // timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int BUS_TIMEOUT_MS = 35;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int STRETCH_PERMILLE = 392;

endpackage

// file: rtl/reading_freeze_hold.sv
// One conversion result held for readout, with read-order freeze.
// Assumes live data and strobes come from the device clock domain.
`timescale 1ns/1ps
module reading_freeze_hold
  import monitor_regs_pkg::*;
#(
  parameter int         W   = CONV_W,
  parameter logic [9:0] RST = CONV_RST
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // live result and read strobes
  input  wire logic [W-1:0] live,
  input  wire logic         freeze_set,
  input  wire logic         release_rd,
  // held result
  output logic      [W-1:0] value,
  output logic              frozen
);

  // set wins over release in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frozen <= 1'b0;
    end else if (freeze_set) begin
      frozen <= 1'b1;
    end else if (release_rd) begin
      frozen <= 1'b0;
    end
  end

  // no update in the cycle of the extended read either
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RST[W-1:0];
    end else if (!frozen && !freeze_set) begin
      value <= live;
    end
  end

endmodule

// file: verification/reg_host_model.sv
// Host side of the register strobe port: single reads and writes.
// Assumes the bank answers reads one cycle after the strobe edge.
`timescale 1ns/1ps
module reg_host_model
  import monitor_regs_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= (a == ADDR_CFG7) ? (d & 8'h1F) : d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench of the monitor configuration and readout bank.
// Assumes the host model drives the register port; bench drives the rest.
`timescale 1ns/1ps
module tb_top;
  import monitor_regs_pkg::*;
  localparam int TO = 20;

  logic                         sys_clk;
  logic                         rst_n;
  logic [7:0]                   reg_addr;
  logic                         reg_wr;
  logic                         reg_rd;
  logic [7:0]                   reg_wdata;
  logic [7:0]                   reg_rdata;
  logic                         cfg_lock;
  logic [NUM_TH-1:0][7:0]       thermal_live;
  logic [NUM_CH-1:0][CONV_W-1:0] conv_live;
  logic [2:0][7:0]              max_duty;
  logic [2:0][7:0]              auto_duty;
  logic [2:0][7:0]              fan_duty;
  logic                         bus_in_txn;
  logic                         bus_activity;
  logic                         bus_release;
  logic                         core_voltage_low_pin;
  logic                         device_sleep;
  logic [2:0]                   smoothing_slow;
  logic                         smoothing_further_stretch;
  logic                         overtemp_hysteresis_off;
  logic                         force_full_fan_speed;
  logic                         cpu_power_calc_flag;
  logic                         spinup_style_select;
  logic                         bus_timeout_off;
  logic                         core_voltage_sleep_ctrl;
  int                           err_total;
  int                           checks_done;

  monitor_config_readout_regs #(.TIMEOUT_CYC(TO)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cfg_lock(cfg_lock),
    .thermal_live(thermal_live), .conv_live(conv_live),
    .max_duty(max_duty), .auto_duty(auto_duty), .fan_duty(fan_duty),
    .bus_in_txn(bus_in_txn), .bus_activity(bus_activity),
    .bus_release(bus_release),
    .core_voltage_low_pin(core_voltage_low_pin),
    .device_sleep(device_sleep), .smoothing_slow(smoothing_slow),
    .smoothing_further_stretch(smoothing_further_stretch),
    .overtemp_hysteresis_off(overtemp_hysteresis_off),
    .force_full_fan_speed(force_full_fan_speed),
    .cpu_power_calc_flag(cpu_power_calc_flag),
    .spinup_style_select(spinup_style_select),
    .bus_timeout_off(bus_timeout_off),
    .core_voltage_sleep_ctrl(core_voltage_sleep_ctrl));

  reg_host_model i_host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(d, e);
  endtask

  function automatic logic [9:0] conv_val(int i, bit b);
    return b ? 10'(i * 83 + 7) : 10'(1000 - i * 71);
  endfunction

  task automatic t_reset_thermal();
    chk({smoothing_slow, smoothing_further_stretch, core_voltage_sleep_ctrl,
         overtemp_hysteresis_off, force_full_fan_speed,
         cpu_power_calc_flag, spinup_style_select,
         bus_timeout_off}, 0);
    rd_chk(ADDR_CFG6, CFG6_RST);
    rd_chk(ADDR_CFG7, CFG7_RST);
    rd_chk(8'h12, 8'h00);
    chk(fan_duty, auto_duty);
    for (int i = 0; i < NUM_TH; i++) thermal_live[i] <= 8'(8'h41 + i * 37);
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < NUM_TH; i++)
      rd_chk(OVERTEMP_SIGNAL_ADDR[i], 8'(8'h41 + i * 37));
  endtask

  task automatic t_config();
    i_host.wr(ADDR_CFG6, 8'hFF);
    rd_chk(ADDR_CFG6, 8'hC7);
    chk({smoothing_further_stretch, core_voltage_sleep_ctrl}, 2'h3);
    i_host.wr(ADDR_CFG6, 8'h05);
    chk(smoothing_slow, 3'h5);
    i_host.wr(ADDR_CFG7, 8'hFF);
    rd_chk(ADDR_CFG7, 8'h1F);
    chk({bus_timeout_off, spinup_style_select, cpu_power_calc_flag,
         force_full_fan_speed,
         overtemp_hysteresis_off}, 5'h1F);
    repeat (2) @(posedge sys_clk);
    chk(fan_duty, max_duty);
    i_host.wr(ADDR_CFG7, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(fan_duty, auto_duty);
  endtask

  task automatic t_sleep();
    i_host.wr(ADDR_CFG6, 8'h40);
    repeat (5) @(posedge sys_clk);
    #1 chk(device_sleep, 1'b0);
    core_voltage_low_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 chk(device_sleep, 1'b1);
    i_host.wr(ADDR_CFG6, 8'h00);
    repeat (5) @(posedge sys_clk);
    #1 chk(device_sleep, 1'b0);
    core_voltage_low_pin <= 1'b0;
  endtask

  task automatic t_timeout(input logic off);
    int first;
    int pulses;
    first  = -1;
    pulses = 0;
    i_host.wr(ADDR_CFG7, {3'h0, off, 4'h0});
    @(posedge sys_clk);
    bus_in_txn <= 1'b1;
    for (int c = 1; c <= TO + 20; c++) begin
      @(posedge sys_clk);
      #1;
      if (bus_release === 1'b1) begin
        pulses++;
        if (first < 0) first = c;
      end
      if (c == 10) bus_activity <= 1'b1;
      if (c == 11) bus_activity <= 1'b0;
    end
    bus_in_txn <= 1'b0;
    if (off) chk(pulses, 0);
    else chk({pulses == 1, first == TO + 11}, 2'h3);
  endtask

  task automatic t_lock();
    i_host.wr(ADDR_CFG6, 8'h87);
    i_host.wr(ADDR_CFG7, 8'h15);
    cfg_lock <= 1'b1;
    i_host.wr(ADDR_CFG6, 8'h00);
    rd_chk(ADDR_CFG6, 8'h87);
    i_host.wr(ADDR_CFG7, 8'h02);
    rd_chk(ADDR_CFG7, 8'h17);
    repeat (2) @(posedge sys_clk);
    chk(fan_duty, max_duty);
    cfg_lock <= 1'b0;
    i_host.wr(ADDR_CFG7, 8'h00);
  endtask

  task automatic t_freeze();
    logic [9:0] a [NUM_CH];
    logic [9:0] b [NUM_CH];
    for (int i = 0; i < NUM_CH; i++) a[i] = conv_val(i, 0);
    for (int i = 0; i < NUM_CH; i++) b[i] = conv_val(i, 1);
    for (int i = 0; i < NUM_CH; i++) conv_live[i] <= a[i];
    repeat (2) @(posedge sys_clk);
    rd_chk(ADDR_EXT3, {a[0][1:0], a[1][1:0], 4'h0});
    repeat (2) @(posedge sys_clk);
    rd_chk(ADDR_EXT1, {a[5][1:0], a[4][1:0], a[3][1:0], a[2][1:0]});
    rd_chk(ADDR_EXT2, {6'h00, a[6][1:0]});
    for (int i = 0; i < NUM_CH; i++) conv_live[i] <= b[i];
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < NUM_CH; i++)
      rd_chk(UPPER_ADDR[i], a[i][9:2]);
    for (int i = 0; i < NUM_CH; i++)
      rd_chk(UPPER_ADDR[i], b[i][9:2]);
  endtask

  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    err_total            = 0;
    checks_done          = 0;
    rst_n                = 1'b0;
    cfg_lock             = 1'b0;
    thermal_live         = '0;
    conv_live            = '0;
    max_duty             = {8'hF0, 8'hE1, 8'hD2};
    auto_duty            = {8'h30, 8'h21, 8'h12};
    bus_in_txn           = 1'b0;
    bus_activity         = 1'b0;
    core_voltage_low_pin = 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(i_dut.thermal, {NUM_TH{OVERTEMP_SIGNAL_RST}});
    rst_n <= 1'b1;
    t_reset_thermal();
    t_config();
    t_sleep();
    t_timeout(1'b0);
    t_timeout(1'b1);
    t_lock();
    t_freeze();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule
